// ===== core/prc_axil_slave.v
/*
  axi4-lite slave front end: takes address and data in either order,
  hands one write and one read at a time to the register file.
  assumes the register file decodes wr_addr and rd_addr combinationally.
*/
`timescale 1ns/1ns
`include "prc_map.vh"

module prc_axil_slave (
    input wire aclk,
    input wire aresetn,
    input wire [`PRC_ADDR_W-1:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [`PRC_ADDR_W-1:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    output wire wr_en,
    output reg [`PRC_ADDR_W-1:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_ok,
    output reg [`PRC_ADDR_W-1:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_ok
);

reg aw_held;
reg w_held;
reg ar_held;

// write commits once both halves are held and no response is pending
assign wr_en = aw_held & w_held & ~bvalid;

// write address, data and response
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b0;
        bresp <= `PRC_RESP_OKAY;
        wr_addr <= {`PRC_ADDR_W{1'b0}};
        wr_data <= 32'h0000_0000;
        wr_strb <= 4'h0;
    end else begin
        if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
        end
        if (wvalid && wready) begin
            w_held <= 1'b1;
            wready <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end
        if (wr_en) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
        end
        if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
        end
    end
end

// read address and data
always @(posedge aclk) begin
    if (!aresetn) begin
        ar_held <= 1'b0;
        arready <= 1'b1;
        rvalid <= 1'b0;
        rresp <= `PRC_RESP_OKAY;
        rdata <= 32'h0000_0000;
        rd_addr <= {`PRC_ADDR_W{1'b0}};
    end else begin
        if (arvalid && arready) begin
            ar_held <= 1'b1;
            arready <= 1'b0;
            rd_addr <= araddr;
        end
        if (ar_held) begin
            ar_held <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_ok ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
        end
        if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
end

endmodule // prc_axil_slave

// ===== core/prc_map.vh
/*
  register map, field positions and reset values of the peripheral reset control block.
  assumes a 32-bit register bus with byte addresses and aligned words.
*/
`ifndef PRC_MAP_VH
`define PRC_MAP_VH

// register byte offsets
`define PRC_OFS_RESET_CTRL 8'h50
`define PRC_OFS_RSVD_WORD 8'h54
`define PRC_OFS_SEQ_FAULT 8'h80
`define PRC_OFS_CLK_VIEW 8'h84
`define PRC_ADDR_W 8

// reset values and bit masks
`define PRC_RESET_CTRL_INIT 32'hF4FF_F33F
`define PRC_RESET_CTRL_MASK 32'hF4FF_F33F
`define PRC_RESET_NON_RTC_MASK 32'hF0FF_F33F
`define PRC_RSVD_WORD_INIT 32'h0000_0000
`define PRC_RSVD_WORD_MASK 32'h0000_00FF
`define PRC_SEQ_FAULT_INIT 32'h0000_0000

// field positions of the reset control register
`define PRC_BIT_CHECKSUM 31
`define PRC_BIT_ACCEL 30
`define PRC_BIT_DMA 29
`define PRC_BIT_COMPARATOR 28
`define PRC_BIT_CALENDAR 26
`define PRC_BIT_FD_BUS 23
`define PRC_BIT_BSERIAL3 22
`define PRC_BIT_TWO_WIRE 21
`define PRC_BIT_BSERIAL2 20
`define PRC_BIT_BSERIAL1 19
`define PRC_BIT_BSERIAL0 18
`define PRC_BIT_SYNC1 17
`define PRC_BIT_SYNC0 16
`define PRC_BIT_MS_TIMER 15
`define PRC_BIT_CONV1 14
`define PRC_BIT_CONV0 13
`define PRC_BIT_MOTOR_PWM 12
`define PRC_BIT_FTIMER1 9
`define PRC_BIT_FTIMER0 8
`define PRC_BIT_TIMER5 5
`define PRC_BIT_TIMER0 0

// bus responses
`define PRC_RESP_OKAY 2'b00
`define PRC_RESP_SLVERR 2'b10

`endif

// ===== core/prc_top.v
/*
  peripheral reset control: one software reset bit per peripheral, a
  reset line to each, a write gate for each peripheral's registers and a
  reserved word, all behind an axi4-lite slave.
  assumes por_resetn and aresetn are already synchronous to aclk, and
  that the clock gating bits and write requests come from aclk logic.
*/
`timescale 1ns/1ns
`include "prc_map.vh"

// Function
// - reset register at 0x50, 1 holds peripheral
// - implemented bits reset to 1, reserved 0
// - calendar bit reloaded by power-on reset only
// - set bit keeps its peripheral in reset
// - set bit blocks writes to peripheral registers
// - bits 31-28, 26, 23, 22-16 upper peripheral map
// - bits 15-12, 9-8, 5-0 lower peripheral map
// - reserved word at 0x54, upper bytes zero
// - companion clock gating bit: 1 supplies clock

module prc_top (
    input wire aclk,
    input wire aresetn,
    input wire por_resetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] peripheral_clock_gating,
    input wire [31:0] periph_wr_req,
    output reg [31:0] periph_wr_grant,
    output reg [31:0] periph_clk_enable,
    output wire checksum_unit_reset,
    output wire accelerator_reset,
    output wire dma_unit_reset,
    output wire comparator_reset,
    output wire calendar_clock_reset,
    output wire fd_bus_reset,
    output wire buffered_serial3_reset,
    output wire two_wire_unit_reset,
    output wire buffered_serial2_reset,
    output wire buffered_serial1_reset,
    output wire buffered_serial0_reset,
    output wire sync_port1_reset,
    output wire sync_port0_reset,
    output wire millisecond_timer_reset,
    output wire converter1_reset,
    output wire converter0_reset,
    output wire motor_pwm_reset,
    output wire function_timer1_reset,
    output wire function_timer0_reset,
    output wire [5:0] timer_reset
);

// register state
reg [31:0] peripheral_reset_control;
reg [31:0] reserved_word_a;
reg [31:0] seq_fault;
reg [31:0] gating_prev;

// slave side signals
wire wr_en;
wire [7:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire [7:0] rd_addr;
reg [31:0] rd_data;
wire wr_ok;
wire rd_ok;
wire [31:0] strb_mask;
wire [31:0] write_bits;

// address decode shared by read and write paths
function [1:0] prc_decode;
    input [7:0] addr;
    begin
        case (addr)
            `PRC_OFS_RESET_CTRL: prc_decode = 2'd0;
            `PRC_OFS_RSVD_WORD: prc_decode = 2'd1;
            `PRC_OFS_SEQ_FAULT: prc_decode = 2'd2;
            `PRC_OFS_CLK_VIEW: prc_decode = 2'd3;
            default: prc_decode = 2'd3;
        endcase
    end
endfunction

// mapped address check shared by read and write paths
function prc_mapped;
    input [7:0] addr;
    begin
        prc_mapped = (addr == `PRC_OFS_RESET_CTRL) || (addr == `PRC_OFS_RSVD_WORD) ||
                     (addr == `PRC_OFS_SEQ_FAULT) || (addr == `PRC_OFS_CLK_VIEW);
    end
endfunction

// bus front end
prc_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
);

assign wr_ok = prc_mapped(wr_addr);
assign rd_ok = prc_mapped(rd_addr);

// byte strobes widened to a bit mask
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_strb
        assign strb_mask[gi*8 +: 8] = {8{wr_strb[gi]}};
    end
endgenerate

// write data merged with the old value under the strobes
assign write_bits = (peripheral_reset_control & ~strb_mask) | (wr_data & strb_mask);

// reset control register; calendar bit kept across non power-on resets
always @(posedge aclk) begin
    if (!por_resetn) begin
        peripheral_reset_control <= `PRC_RESET_CTRL_INIT;
    end else if (!aresetn) begin
        peripheral_reset_control <= (`PRC_RESET_CTRL_INIT & `PRC_RESET_NON_RTC_MASK) |
            (peripheral_reset_control & ~`PRC_RESET_NON_RTC_MASK);
    end else if (wr_en && prc_mapped(wr_addr) && prc_decode(wr_addr) == 2'd0) begin
        peripheral_reset_control <= write_bits & `PRC_RESET_CTRL_MASK;
    end
end

// reserved word: only the low byte holds a value
always @(posedge aclk) begin
    if (!aresetn || !por_resetn) begin
        reserved_word_a <= `PRC_RSVD_WORD_INIT;
    end else if (wr_en && wr_addr == `PRC_OFS_RSVD_WORD) begin
        reserved_word_a <= ((reserved_word_a & ~strb_mask) | (wr_data & strb_mask)) &
            `PRC_RSVD_WORD_MASK;
    end
end

// previous gating view for order checking
always @(posedge aclk) begin
    if (!aresetn || !por_resetn) begin
        gating_prev <= 32'h0000_0000;
    end else begin
        gating_prev <= peripheral_clock_gating & `PRC_RESET_CTRL_MASK;
    end
end

// order fault flags: release without clock, or clock stop while running
wire [31:0] release_now;
wire [31:0] bring_up_fault;
wire [31:0] shut_down_fault;
wire [31:0] fault_clear;
assign release_now = (wr_en && wr_addr == `PRC_OFS_RESET_CTRL) ?
    (peripheral_reset_control & ~write_bits & `PRC_RESET_CTRL_MASK) : 32'h0000_0000;
assign bring_up_fault = release_now & ~peripheral_clock_gating;
assign shut_down_fault = gating_prev & ~peripheral_clock_gating &
    ~peripheral_reset_control & `PRC_RESET_CTRL_MASK;
assign fault_clear = (wr_en && wr_addr == `PRC_OFS_SEQ_FAULT) ?
    (wr_data & strb_mask) : 32'h0000_0000;

// sticky flags, write one to clear, a new fault wins over the clear
always @(posedge aclk) begin
    if (!aresetn || !por_resetn) begin
        seq_fault <= `PRC_SEQ_FAULT_INIT;
    end else begin
        seq_fault <= (seq_fault & ~fault_clear) | bring_up_fault | shut_down_fault;
    end
end

// register read mux
always @* begin
    rd_data = 32'h0000_0000;
    if (prc_mapped(rd_addr)) begin
        case (prc_decode(rd_addr))
            2'd0: rd_data = peripheral_reset_control & `PRC_RESET_CTRL_MASK;
            2'd1: rd_data = reserved_word_a & `PRC_RSVD_WORD_MASK;
            2'd2: rd_data = seq_fault;
            2'd3: rd_data = peripheral_clock_gating & `PRC_RESET_CTRL_MASK;
            default: rd_data = 32'h0000_0000;
        endcase
    end
end

// write gate: clock supplied and reset released, else the write is dropped
always @(posedge aclk) begin
    if (!aresetn || !por_resetn) begin
        periph_wr_grant <= 32'h0000_0000;
    end else begin
        periph_wr_grant <= periph_wr_req & ~peripheral_reset_control &
            peripheral_clock_gating & `PRC_RESET_CTRL_MASK;
    end
end

// clock enables follow the companion gating bits
always @(posedge aclk) begin
    if (!aresetn || !por_resetn) begin
        periph_clk_enable <= 32'h0000_0000;
    end else begin
        periph_clk_enable <= peripheral_clock_gating & `PRC_RESET_CTRL_MASK;
    end
end

// reset lines straight from the register bits
assign checksum_unit_reset = peripheral_reset_control[`PRC_BIT_CHECKSUM];
assign accelerator_reset = peripheral_reset_control[`PRC_BIT_ACCEL];
assign dma_unit_reset = peripheral_reset_control[`PRC_BIT_DMA];
assign comparator_reset = peripheral_reset_control[`PRC_BIT_COMPARATOR];
assign calendar_clock_reset = peripheral_reset_control[`PRC_BIT_CALENDAR];
assign fd_bus_reset = peripheral_reset_control[`PRC_BIT_FD_BUS];
assign buffered_serial3_reset = peripheral_reset_control[`PRC_BIT_BSERIAL3];
assign two_wire_unit_reset = peripheral_reset_control[`PRC_BIT_TWO_WIRE];
assign buffered_serial2_reset = peripheral_reset_control[`PRC_BIT_BSERIAL2];
assign buffered_serial1_reset = peripheral_reset_control[`PRC_BIT_BSERIAL1];
assign buffered_serial0_reset = peripheral_reset_control[`PRC_BIT_BSERIAL0];
assign sync_port1_reset = peripheral_reset_control[`PRC_BIT_SYNC1];
assign sync_port0_reset = peripheral_reset_control[`PRC_BIT_SYNC0];
assign millisecond_timer_reset = peripheral_reset_control[`PRC_BIT_MS_TIMER];
assign converter1_reset = peripheral_reset_control[`PRC_BIT_CONV1];
assign converter0_reset = peripheral_reset_control[`PRC_BIT_CONV0];
assign motor_pwm_reset = peripheral_reset_control[`PRC_BIT_MOTOR_PWM];
assign function_timer1_reset = peripheral_reset_control[`PRC_BIT_FTIMER1];
assign function_timer0_reset = peripheral_reset_control[`PRC_BIT_FTIMER0];
assign timer_reset = peripheral_reset_control[`PRC_BIT_TIMER5:`PRC_BIT_TIMER0];

endmodule // prc_top

// ===== tb/prc_checker.sv
/*
  checker for prc_top: reset lines, write gate and bus timing.
  assumes the bind at the foot of this file and prc_map.vh on the include path.
*/
`timescale 1ns/1ns
`include "prc_map.vh"

module prc_checker (
    input wire aclk, aresetn, por_resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire [7:0] s_axi_awaddr, s_axi_araddr,
    input wire [3:0] s_axi_wstrb,
    input wire [1:0] s_axi_rresp,
    input wire [31:0] s_axi_wdata, s_axi_rdata, peripheral_clock_gating, periph_wr_req, periph_wr_grant,
    input wire [31:0] periph_clk_enable,
    input wire checksum_unit_reset, accelerator_reset, dma_unit_reset, comparator_reset, calendar_clock_reset,
    input wire fd_bus_reset, buffered_serial3_reset, two_wire_unit_reset, buffered_serial2_reset,
    input wire buffered_serial1_reset, buffered_serial0_reset, sync_port1_reset, sync_port0_reset,
    input wire millisecond_timer_reset, converter1_reset, converter0_reset, motor_pwm_reset,
    input wire function_timer1_reset, function_timer0_reset,
    input wire [5:0] timer_reset
);
    // reset lines gathered at their register positions
    wire [31:0] rv = {checksum_unit_reset, accelerator_reset, dma_unit_reset, comparator_reset, 1'b0,
        calendar_clock_reset, 2'b00, fd_bus_reset, buffered_serial3_reset, two_wire_unit_reset,
        buffered_serial2_reset, buffered_serial1_reset, buffered_serial0_reset, sync_port1_reset,
        sync_port0_reset, millisecond_timer_reset, converter1_reset, converter0_reset, motor_pwm_reset,
        2'b00, function_timer1_reset, function_timer0_reset, 2'b00, timer_reset};

    a_por_load: assert property (@(posedge aclk) !por_resetn |=> rv == `PRC_RESET_CTRL_INIT)
        else $error("reset lines differ from init after power-on reset");
    a_warm_keeps_cal: assert property (@(posedge aclk) por_resetn && !aresetn |=>
        (rv & `PRC_RESET_NON_RTC_MASK) == `PRC_RESET_NON_RTC_MASK && rv[26] == $past(rv[26]))
        else $error("system reset reloaded the calendar bit or missed another bit");
    a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn || !por_resetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'hf
        && s_axi_awaddr == `PRC_OFS_RESET_CTRL |-> ##2 rv == ($past(s_axi_wdata, 2) & `PRC_RESET_CTRL_MASK))
        else $error("reset lines do not follow the written word");
    a_grant_gate: assert property (@(posedge aclk) disable iff (!aresetn || !por_resetn)
        1'b1 |=> periph_wr_grant == ($past(periph_wr_req & ~rv & peripheral_clock_gating) & `PRC_RESET_CTRL_MASK))
        else $error("write grant ignores the reset bit");
    a_clk_follow: assert property (@(posedge aclk) disable iff (!aresetn || !por_resetn)
        1'b1 |=> periph_clk_enable == ($past(peripheral_clock_gating) & `PRC_RESET_CTRL_MASK))
        else $error("clock enable does not follow gating bits");
    a_rsvd_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (periph_wr_grant & ~`PRC_RESET_CTRL_MASK) == 32'h0000_0000 &&
        (periph_clk_enable & ~`PRC_RESET_CTRL_MASK) == 32'h0000_0000)
        else $error("reserved position drives a peripheral");
    a_rsvd_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRC_OFS_RESET_CTRL |->
        ##2 (s_axi_rdata & ~`PRC_RESET_CTRL_MASK) == 32'h0000_0000)
        else $error("reserved reset bit reads nonzero");
    a_rsvd_word: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRC_OFS_RSVD_WORD |-> ##2 s_axi_rdata[31:8] == 24'h00_0000)
        else $error("reserved word reads nonzero upper bits");
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
        else $error("read answer late");
endmodule // prc_checker

bind prc_top prc_checker u_checker (.*);

// ===== tb/prc_periph_model.sv
/*
  model of the peripherals fed by the reset block: each keeps a flag
  that a granted write sets and its reset line clears.
  assumes the block's clock.
*/
`timescale 1ns/1ns

module prc_periph_model (
    input wire aclk,
    input wire [31:0] rst_lines,
    input wire [31:0] clk_en,
    input wire [31:0] grant,
    output reg [31:0] written
);
    initial written = 32'h0000_0000;
    // stored only with clock running and out of reset
    always @(posedge aclk) begin
        written <= (written | (grant & clk_en)) & ~rst_lines;
    end
endmodule // prc_periph_model

// ===== tb/prc_top_tb.sv
/*
  testbench for prc_top: bus tasks, one task per scenario, a peripheral model.
  assumes prc_checker is bound by its own file.
*/
`timescale 1ns/1ns
`include "prc_map.vh"

module prc_top_tb;
    reg aclk = 1'b0, aresetn = 1'b0, por_resetn = 1'b0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [3:0] s_axi_wstrb = 4'h0;
    reg [31:0] s_axi_wdata = 32'h0000_0000, peripheral_clock_gating = 32'h0000_0000, periph_wr_req = 32'h0000_0000;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, periph_wr_grant, periph_clk_enable, written;
    wire checksum_unit_reset, accelerator_reset, dma_unit_reset, comparator_reset, calendar_clock_reset;
    wire fd_bus_reset, buffered_serial3_reset, two_wire_unit_reset, buffered_serial2_reset;
    wire buffered_serial1_reset, buffered_serial0_reset, sync_port1_reset, sync_port0_reset;
    wire millisecond_timer_reset, converter1_reset, converter0_reset, motor_pwm_reset;
    wire function_timer1_reset, function_timer0_reset;
    wire [5:0] timer_reset;
    wire [31:0] rv = {checksum_unit_reset, accelerator_reset, dma_unit_reset, comparator_reset, 1'b0,
        calendar_clock_reset, 2'b00, fd_bus_reset, buffered_serial3_reset, two_wire_unit_reset,
        buffered_serial2_reset, buffered_serial1_reset, buffered_serial0_reset, sync_port1_reset,
        sync_port0_reset, millisecond_timer_reset, converter1_reset, converter0_reset, motor_pwm_reset,
        2'b00, function_timer1_reset, function_timer0_reset, 2'b00, timer_reset};
    integer err_count = 0, comparisons = 0;
    localparam [31:0] MASK = `PRC_RESET_CTRL_MASK;

    prc_top dut (.*);
    prc_periph_model u_periph (.aclk(aclk), .rst_lines(rv), .clk_en(periph_clk_enable),
        .grant(periph_wr_grant), .written(written));

    // 10 MHz clock
    always #50 aclk = ~aclk;

    task check(input string name, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected %0s: expected %h, seen %h", name, exp, got);
            end
        end
    endtask

    // one write, address and data offered together
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            @(posedge aclk);
            while (s_axi_awvalid || s_axi_wvalid) begin
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                @(posedge aclk);
            end
            // bready stays high between writes so it is never driven twice in one step
            while (!s_axi_bvalid) @(posedge aclk);
            check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        end
    endtask

    // one read, data and response compared
    task rdc(input [7:0] a, input [31:0] ed, input [1:0] er);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            @(posedge aclk);
            while (!s_axi_arready) @(posedge aclk);
            s_axi_arvalid <= 1'b0;
            s_axi_rready <= 1'b1;
            @(posedge aclk);
            while (!s_axi_rvalid) @(posedge aclk);
            s_axi_rready <= 1'b0;
            check("rdata", ed, s_axi_rdata);
            check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        end
    endtask

    task t_init;
        begin
            check("lines", `PRC_RESET_CTRL_INIT, rv);
            rdc(`PRC_OFS_RESET_CTRL, `PRC_RESET_CTRL_INIT, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_RSVD_WORD, 32'h0000_0000, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_SEQ_FAULT, `PRC_SEQ_FAULT_INIT, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_CLK_VIEW, 32'h0000_0000, `PRC_RESP_OKAY);
        end
    endtask

    // release one line at a time, then all ones and all zeros
    task t_map;
        integer i;
        begin
            peripheral_clock_gating <= 32'hFFFF_FFFF;
            for (i = 0; i < 32; i = i + 1) begin
                if (MASK[i]) begin
                    wr(`PRC_OFS_RESET_CTRL, MASK & ~(32'h0000_0001 << i), `PRC_RESP_OKAY);
                    check("lines", MASK & ~(32'h0000_0001 << i), rv);
                end
            end
            wr(`PRC_OFS_RESET_CTRL, 32'hFFFF_FFFF, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_RESET_CTRL, MASK, `PRC_RESP_OKAY);
            wr(`PRC_OFS_RESET_CTRL, 32'h0000_0000, `PRC_RESP_OKAY);
            check("lines", 32'h0000_0000, rv);
        end
    endtask

    // bring-up and shutdown of timers 5 and 4 in the required order
    task t_gate;
        begin
            wr(`PRC_OFS_RESET_CTRL, MASK, `PRC_RESP_OKAY);
            peripheral_clock_gating <= 32'hFFFF_FFF0;
            periph_wr_req <= 32'hFFFF_FFFF;
            wr(`PRC_OFS_RESET_CTRL, MASK & ~32'h0000_0030, `PRC_RESP_OKAY);
            repeat (2) @(posedge aclk);
            check("grant", 32'h0000_0030, periph_wr_grant);
            check("clk_en", MASK & 32'hFFFF_FFF0, periph_clk_enable);
            check("written", 32'h0000_0030, written & MASK);
            wr(`PRC_OFS_RESET_CTRL, MASK, `PRC_RESP_OKAY);
            peripheral_clock_gating <= 32'h0000_0000;
            repeat (2) @(posedge aclk);
            check("grant", 32'h0000_0000, periph_wr_grant);
            check("written", 32'h0000_0000, written & MASK);
            periph_wr_req <= 32'h0000_0000;
        end
    endtask

    task t_rsvd;
        begin
            wr(`PRC_OFS_RSVD_WORD, 32'hFFFF_FFFF, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_RSVD_WORD, 32'h0000_00FF, `PRC_RESP_OKAY);
            wr(8'h10, 32'h0000_0000, `PRC_RESP_SLVERR);
            rdc(8'h10, 32'h0000_0000, `PRC_RESP_SLVERR);
            rdc(`PRC_OFS_RESET_CTRL, MASK, `PRC_RESP_OKAY);
        end
    endtask

    // order faults: timer 0 released without clock, timer 1 clock stopped while running
    task t_order;
        begin
            peripheral_clock_gating <= 32'h0000_0002;
            wr(`PRC_OFS_RESET_CTRL, MASK & ~32'h0000_0001, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_CLK_VIEW, 32'h0000_0002, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_SEQ_FAULT, 32'h0000_0001, `PRC_RESP_OKAY);
            wr(`PRC_OFS_RESET_CTRL, MASK & ~32'h0000_0003, `PRC_RESP_OKAY);
            peripheral_clock_gating <= 32'h0000_0000;
            wr(`PRC_OFS_SEQ_FAULT, 32'h0000_0001, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_SEQ_FAULT, 32'h0000_0002, `PRC_RESP_OKAY);
            wr(`PRC_OFS_SEQ_FAULT, 32'hFFFF_FFFF, `PRC_RESP_OKAY);
            rdc(`PRC_OFS_SEQ_FAULT, 32'h0000_0000, `PRC_RESP_OKAY);
        end
    endtask

    // system reset keeps the calendar bit, power-on reset reloads it
    task t_warm(input por);
        begin
            peripheral_clock_gating <= 32'hFFFF_FFFF;
            wr(`PRC_OFS_RESET_CTRL, 32'h0000_0000, `PRC_RESP_OKAY);
            aresetn <= 1'b0;
            por_resetn <= ~por;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            por_resetn <= 1'b1;
            @(posedge aclk);
            rdc(`PRC_OFS_RESET_CTRL, por ? MASK : `PRC_RESET_NON_RTC_MASK, `PRC_RESP_OKAY);
        end
    endtask

    task test_done;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        por_resetn <= 1'b1;
        @(posedge aclk);
        t_init;
        t_map;
        t_gate;
        t_rsvd;
        t_order;
        t_warm(1'b0);
        t_warm(1'b1);
        test_done;
    end

    // watchdog, far beyond the few hundred cycles needed
    initial begin
        #500000;
        err_count = err_count + 1;
        test_done;
    end
endmodule // prc_top_tb
